// File: src/hpa_edge_filter.sv
// Pulse-width glitch filter for one select pin in edge-triggered operation.
`timescale 1ns/10ps
`default_nettype none
module hpa_edge_filter (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic [hpa_pkg::DELAY_W-1:0] low_ticks_i,
  hpa_pin_if.filt pin
);

  logic [hpa_pkg::HIGH_W-1:0] high_cnt_reg;
  logic [hpa_pkg::DELAY_W-1:0] low_cnt_reg;
  logic armed_reg;
  logic fired_reg;
  logic edge_reg;

  wire high_long = high_cnt_reg >= hpa_pkg::HIGH_W'(hpa_pkg::MIN_HIGH_CYC - 1);
  wire low_long = low_cnt_reg >= low_ticks_i;
  wire accept = enable_i && armed_reg && !fired_reg && pin.pin_sync && high_long;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !enable_i) begin
      high_cnt_reg <= '0;
      low_cnt_reg <= '0;
      armed_reg <= 1'b1;
      fired_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      edge_reg <= accept;
      if (pin.pin_sync) begin
        low_cnt_reg <= '0;
        if (!high_long) high_cnt_reg <= high_cnt_reg + 1'b1;
        if (accept) fired_reg <= 1'b1;
      end else begin
        high_cnt_reg <= '0;
        // Low time is counted in delay-timer ticks; a short low does not re-arm.
        if (tick_i && !low_long) low_cnt_reg <= low_cnt_reg + 1'b1;
        if (fired_reg && low_long) begin
          fired_reg <= 1'b0;
          armed_reg <= 1'b1;
        end else if (fired_reg) begin
          armed_reg <= 1'b0;
        end
      end
    end
  end

  assign pin.edge_pulse = edge_reg;

  a_one_accept_per_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    edge_reg |=> !edge_reg) else $error("edge accepted twice in a row");
  a_high_min_width: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    accept |-> $past(pin.pin_sync, 1) && $past(pin.pin_sync, 2)) else $error("edge taken on short pulse");

endmodule
`default_nettype wire

// File: src/hpa_pin_if.sv
// Interface carrying one synchronised select pin and its accepted-edge pulse.
`timescale 1ns/10ps
`default_nettype none
interface hpa_pin_if;
  logic pin_sync;
  logic edge_pulse;
  modport filt (input pin_sync, output edge_pulse);
  modport core (output pin_sync, input edge_pulse);
endinterface
`default_nettype wire

// File: src/hpa_pkg.sv
// Package of constants and types for the host port assignment block.
package hpa_pkg;

  localparam int NUM_PORTS = 4;
  localparam int NUM_CFGS = 8;
  localparam int CODE_W = 3;
  localparam int DELAY_W = 8;

  // Owner encoding of one downstream port.
  typedef enum logic [1:0] {
    HPA_HOST_ONE = 2'h0,
    HPA_HOST_TWO = 2'h1,
    HPA_NO_OWNER = 2'h2
  } hpa_owner_e;

  // Method strap codes.
  localparam logic [2:0] STRAP_EMBEDDED = 3'h0;
  localparam logic [2:0] STRAP_LEVEL = 3'h2;
  localparam logic [2:0] STRAP_EDGE_A = 3'h4;
  localparam logic [2:0] STRAP_EDGE_B = 3'h5;

  typedef enum logic [1:0] {
    HPA_MODE_EMBEDDED,
    HPA_MODE_LEVEL,
    HPA_MODE_EDGE,
    HPA_MODE_OFF
  } hpa_mode_e;

  // Built-in embedded table: port1 in bits 1:0 up to port4 in bits 7:6.
  localparam logic [7:0] EMB_CFG0 = 8'h00;
  localparam logic [7:0] EMB_CFG1 = 8'h55;
  localparam logic [7:0] EMB_CFG2 = 8'h50;
  localparam logic [7:0] EMB_CFG3 = 8'h40;
  localparam logic [7:0] EMB_CFG4 = 8'h15;
  localparam logic [7:0] EMB_CFG5 = 8'h01;
  localparam logic [7:0] EMB_CFG6 = 8'h90;
  localparam logic [7:0] EMB_CFG7 = 8'h80;

  // Timing: least high pulse width and the length of one delay-timer unit.
  localparam int CLK_PERIOD_NS = 40;
  localparam int MIN_HIGH_NS = 100;
  localparam int MIN_HIGH_CYC = (MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int TICK_W = 6;
  localparam int HIGH_W = 3;

endpackage

// File: src/hpa_port_assign.sv
// Top of the host port assignment block: pin sync, mode, delay and owner state.
//
// How it works
// - Select pins are ignored while reset is held.
// - Embedded mode decodes only the three low select pins.
// - Codes 0-3 map to the built-in owner tables for ports 1-4.
// - Codes 4-7 map to the built-in owner tables, port 4 unassigned in 6-7.
// - Each embedded table entry can be overridden by a loaded value.
// - Embedded and level assignments apply only after the programmable delay.
// - Level mode: pin n low gives port n+1 to host one, high to two.
// - An edge counts only when its high pulse lasts at least 100 ns.
// - After an edge, a low of the delay-timer length must pass.
// - With unassigned support, edges cycle host one, host two, none.
// - Without unassigned support, edges toggle host one and host two.
// - Edge mode starts with every port owned by host one.
// - Method straps are captured at reset release and select the mode.
// - Level mode has no unassigned state; edge modes do.
`timescale 1ns/10ps
`default_nettype none
module hpa_port_assign #(
  parameter int TICK_CYCLES = hpa_pkg::TICK_CYC,
  // Edge modes may leave a port unassigned; clear this for a plain two-host toggle.
  parameter bit EDGE_NO_OWNER = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [hpa_pkg::NUM_PORTS-1:0] owner_select_pins_i,
  input wire logic method_strap_bit0_i,
  input wire logic method_strap_bit1_i,
  input wire logic method_strap_bit2_i,
  input wire logic [hpa_pkg::DELAY_W-1:0] delay_timer_i,
  input wire logic [hpa_pkg::NUM_CFGS-1:0] cfg_override_en_i,
  input wire logic [hpa_pkg::NUM_CFGS*8-1:0] cfg_override_i,
  output logic [hpa_pkg::NUM_PORTS*2-1:0] port_owner_o,
  output logic [1:0] mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and mode.

  logic in_reset_reg;
  logic [2:0] strap_reg;
  hpa_pkg::hpa_mode_e mode_reg;
  hpa_pkg::hpa_mode_e mode_next;

  always_comb begin
    unique case (strap_reg)
      hpa_pkg::STRAP_EMBEDDED: mode_next = hpa_pkg::HPA_MODE_EMBEDDED;
      hpa_pkg::STRAP_LEVEL: mode_next = hpa_pkg::HPA_MODE_LEVEL;
      hpa_pkg::STRAP_EDGE_A, hpa_pkg::STRAP_EDGE_B: mode_next = hpa_pkg::HPA_MODE_EDGE;
      default: mode_next = hpa_pkg::HPA_MODE_OFF;
    endcase
  end

  // Straps are caught on the first clock after release, never under reset.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      in_reset_reg <= 1'b1;
      strap_reg <= '0;
    end else if (in_reset_reg) begin
      in_reset_reg <= 1'b0;
      strap_reg <= {method_strap_bit2_i, method_strap_bit1_i, method_strap_bit0_i};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || in_reset_reg) mode_reg <= hpa_pkg::HPA_MODE_OFF;
    else mode_reg <= mode_next;
  end

  wire running = !in_reset_reg && (mode_reg != hpa_pkg::HPA_MODE_OFF);
  wire edge_mode = mode_reg == hpa_pkg::HPA_MODE_EDGE;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and delay-timer tick.

  logic [hpa_pkg::NUM_PORTS-1:0] sync1_reg;
  logic [hpa_pkg::NUM_PORTS-1:0] sync2_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= owner_select_pins_i;
      sync2_reg <= sync1_reg;
    end
  end

  logic [hpa_pkg::TICK_W-1:0] tick_cnt_reg;
  wire tick = tick_cnt_reg == hpa_pkg::TICK_W'(TICK_CYCLES - 1);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || tick) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Embedded and level target, held for the switching delay.

  function automatic logic [7:0] emb_default(input logic [2:0] code);
    case (code)
      3'h0: emb_default = hpa_pkg::EMB_CFG0;
      3'h1: emb_default = hpa_pkg::EMB_CFG1;
      3'h2: emb_default = hpa_pkg::EMB_CFG2;
      3'h3: emb_default = hpa_pkg::EMB_CFG3;
      3'h4: emb_default = hpa_pkg::EMB_CFG4;
      3'h5: emb_default = hpa_pkg::EMB_CFG5;
      3'h6: emb_default = hpa_pkg::EMB_CFG6;
      default: emb_default = hpa_pkg::EMB_CFG7;
    endcase
  endfunction

  wire [2:0] emb_code = sync2_reg[hpa_pkg::CODE_W-1:0];
  wire [7:0] emb_table = cfg_override_en_i[emb_code] ? cfg_override_i[emb_code*8 +: 8]
                                                     : emb_default(emb_code);
  wire [7:0] level_map = {1'b0, sync2_reg[3], 1'b0, sync2_reg[2],
                          1'b0, sync2_reg[1], 1'b0, sync2_reg[0]};
  wire [7:0] target = (mode_reg == hpa_pkg::HPA_MODE_LEVEL) ? level_map : emb_table;

  logic [7:0] pending_reg;
  logic [hpa_pkg::DELAY_W-1:0] wait_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Edge filters, one per pin.

  logic [hpa_pkg::NUM_PORTS-1:0] edge_hit;

  for (genvar p = 0; p < hpa_pkg::NUM_PORTS; p++) begin : g_pin
    hpa_pin_if pin_bus ();
    assign pin_bus.pin_sync = sync2_reg[p];
    assign edge_hit[p] = pin_bus.edge_pulse;
    hpa_edge_filter u_filt (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .enable_i(running && edge_mode),
      .tick_i(tick),
      .low_ticks_i(delay_timer_i),
      .pin(pin_bus)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Owner state.

  // Without unassigned support host two falls straight back to host one.
  function automatic logic [1:0] next_owner(input logic [1:0] cur, input logic allow_none);
    unique case (cur)
      2'(hpa_pkg::HPA_HOST_ONE): next_owner = 2'(hpa_pkg::HPA_HOST_TWO);
      2'(hpa_pkg::HPA_HOST_TWO): begin
        if (allow_none) next_owner = 2'(hpa_pkg::HPA_NO_OWNER);
        else next_owner = 2'(hpa_pkg::HPA_HOST_ONE);
      end
      default: next_owner = 2'(hpa_pkg::HPA_HOST_ONE);
    endcase
  endfunction

  logic [7:0] owner_reg;
  logic [7:0] owner_edge_next;

  always_comb begin
    owner_edge_next = owner_reg;
    for (int p = 0; p < hpa_pkg::NUM_PORTS; p++) begin
      if (edge_hit[p]) owner_edge_next[p*2 +: 2] = next_owner(owner_reg[p*2 +: 2], EDGE_NO_OWNER);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !running) begin
      owner_reg <= '0;
      pending_reg <= '0;
      wait_reg <= '0;
    end else if (edge_mode) begin
      owner_reg <= owner_edge_next;
    end else if (target != pending_reg) begin
      // Any change restarts the delay, so a bouncing switch settles first.
      pending_reg <= target;
      wait_reg <= '0;
    end else if (wait_reg < delay_timer_i) begin
      if (tick) wait_reg <= wait_reg + 1'b1;
    end else begin
      owner_reg <= pending_reg;
    end
  end

  assign port_owner_o = owner_reg;
  assign mode_o = mode_reg;

  a_emb_delay_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (running && !edge_mode && $changed(owner_reg)) |-> $past(wait_reg) >= $past(delay_timer_i))
    else $error("owner changed before switching delay");
  a_level_no_owner: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (mode_reg == hpa_pkg::HPA_MODE_LEVEL) |-> (owner_reg & 8'haa) == 8'h00)
    else $error("unassigned state in level mode");
  a_edge_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (EDGE_NO_OWNER && edge_mode && running && edge_hit[0] && owner_reg[1:0] == 2'h1) |=> owner_reg[1:0] == 2'h2)
    else $error("host two did not advance to unassigned");
  a_reset_owner: assert property (@(posedge clk_sys_i)
    !rst_b_i |=> owner_reg == 8'h00) else $error("owners not host one after reset");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the two-host toggle, idle edges and the method choice.

  a_edge_toggle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!EDGE_NO_OWNER && edge_mode && running && edge_hit[0] && owner_reg[1:0] == 2'h1) |=> owner_reg[1:0] == 2'h0)
    else $error("host two did not return to host one");
  a_toggle_no_owner: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!EDGE_NO_OWNER && edge_mode) |-> (owner_reg & 8'haa) == 8'h00)
    else $error("unassigned state without unassigned support");
  a_edge_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (edge_mode && running && edge_hit == '0) |=> $stable(owner_reg))
    else $error("owner moved without an accepted edge");
  a_off_owner: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (mode_reg == hpa_pkg::HPA_MODE_OFF) |-> owner_reg == 8'h00)
    else $error("owner set while no method is active");
  a_mode_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    running |=> $stable(mode_reg))
    else $error("method changed outside reset");

endmodule
`default_nettype wire

// File: verification/hpa_switch_model.sv
// Model of the external switches or controller outputs that drive the select pins.
`timescale 1ns/10ps
`default_nettype none
module hpa_switch_model (
  input wire logic clk_i,
  output var logic [3:0] pins_o
);
  initial pins_o = 4'h0;
  task set_levels(input logic [3:0] v);
    pins_o = v;
  endtask
  // A press shorter than the least width is only issued where a refusal is wanted.
  task press(input int idx, input int hi, input int lo);
    @(negedge clk_i);
    pins_o[idx] = 1'b1;
    repeat (hi) @(negedge clk_i);
    pins_o[idx] = 1'b0;
    repeat (lo) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the host port assignment block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [7:0] delay_timer = 8'h00;
  logic [7:0] ovr_en = 8'h00;
  logic [63:0] ovr = 64'h0;
  wire [3:0] pins;
  logic [7:0] port_owner;
  logic [1:0] mode;
  logic [7:0] port_owner_t;
  int errors = 0;
  int total_checks = 0;
  int emb[8][4] = '{'{0, 0, 0, 0}, '{1, 1, 1, 1}, '{0, 0, 1, 1}, '{0, 0, 0, 1},
                    '{1, 1, 1, 0}, '{1, 0, 0, 0}, '{0, 0, 1, 2}, '{0, 0, 0, 2}};
  int own[4];
  int own_t[4];
  always #20 clk_sys_i = ~clk_sys_i;
  hpa_switch_model sw (.clk_i(clk_sys_i), .pins_o(pins));
  // A short tick keeps the delay counts brief; expectations follow this value.
  hpa_port_assign #(.TICK_CYCLES(2)) uut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .owner_select_pins_i(pins),
    .method_strap_bit0_i(strap[0]), .method_strap_bit1_i(strap[1]), .method_strap_bit2_i(strap[2]),
    .delay_timer_i(delay_timer), .cfg_override_en_i(ovr_en), .cfg_override_i(ovr),
    .port_owner_o(port_owner), .mode_o(mode));
  // A copy built without the unassigned state shows the plain two-host toggle.
  hpa_port_assign #(.TICK_CYCLES(2), .EDGE_NO_OWNER(1'b0)) uut_toggle (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .owner_select_pins_i(pins),
    .method_strap_bit0_i(strap[0]), .method_strap_bit1_i(strap[1]), .method_strap_bit2_i(strap[2]),
    .delay_timer_i(delay_timer), .cfg_override_en_i(ovr_en), .cfg_override_i(ovr),
    .port_owner_o(port_owner_t), .mode_o());
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pack_own();
    logic [7:0] v;
    v = 8'h00;
    for (int p = 0; p < 4; p++) v[2*p +: 2] = own[p][1:0];
    return v;
  endfunction
  function automatic logic [7:0] pack_toggle();
    logic [7:0] v;
    v = 8'h00;
    for (int p = 0; p < 4; p++) v[2*p +: 2] = own_t[p][1:0];
    return v;
  endfunction
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wait_owner(input logic [7:0] exp);
    int n;
    for (n = 0; n < 200 && port_owner !== exp; n++) @(negedge clk_sys_i);
    if (n == 200) begin
      errors++;
      $display("MISMATCH owner_wait expected %h seen %h", exp, port_owner);
      report_and_stop();
    end
  endtask
  // Pins move while reset is held; the last reset cycle parks them low.
  task do_reset(input logic [2:0] s, input logic [7:0] d);
    logic [7:0] m;
    @(negedge clk_sys_i);
    rst_b_i = 1'b0;
    strap = s;
    delay_timer = d;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys_i);
      sw.set_levels(i == 4 ? 4'h0 : 4'($urandom));
      check("owner_in_reset", port_owner, 8'h00);
    end
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    m = (s == 3'h0) ? 8'h0 : (s == 3'h2) ? 8'h1 : (s == 3'h4 || s == 3'h5) ? 8'h2 : 8'h3;
    check("mode", {6'h0, mode}, m);
    check("owner_after_reset", port_owner, 8'h00);
    check("owner_after_reset_t", port_owner_t, 8'h00);
    for (int p = 0; p < 4; p++) begin
      own[p] = 0;
      own_t[p] = 0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int c;
    logic [7:0] prev;
    logic [3:0] v;
    void'($urandom(32'hda625b3d));
    do_reset(3'h0, 8'h03);
    for (int k = 0; k < 16; k++) begin
      c = k % 8;
      for (int p = 0; p < 32; p++) ovr[2*p +: 2] = 2'($urandom % 3);
      ovr_en = (k >= 8) ? (8'h01 << c) : 8'h00;
      for (int p = 0; p < 4; p++) own[p] = (k >= 8) ? int'(ovr[8*c+2*p +: 2]) : emb[c][p];
      prev = port_owner;
      sw.set_levels({1'($urandom), 3'(c)});
      if (pack_own() !== prev) begin
        // Eight cycles pass the sync and latch but not three ticks and the owner load, so an early switch shows.
        repeat (8) @(negedge clk_sys_i);
        check("emb_hold", port_owner, prev);
      end
      wait_owner(pack_own());
      check("emb_owner", port_owner, pack_own());
    end
    ovr_en = 8'h00;
    do_reset(3'h2, 8'h01);
    for (int k = 0; k < 8; k++) begin
      v = 4'($urandom);
      for (int p = 0; p < 4; p++) own[p] = v[p];
      prev = port_owner;
      sw.set_levels(v);
      if (pack_own() !== prev) begin
        repeat (4) @(negedge clk_sys_i);
        check("level_hold", port_owner, prev);
      end
      wait_owner(pack_own());
      check("level_owner", port_owner, pack_own());
    end
    for (int s = 4; s < 6; s++) begin
      do_reset(3'(s), 8'h02);
      for (int p = 0; p < 4; p++) begin
        sw.press(p, 2, 12);
        check("short_pulse", port_owner, pack_own());
        check("short_pulse_t", port_owner_t, pack_toggle());
        for (int j = 0; j < 2; j++) begin
          sw.press(p, 4, 12);
          own[p] = (own[p] + 1) % 3;
          own_t[p] = 1 - own_t[p];
          wait_owner(pack_own());
          check("edge_owner", port_owner, pack_own());
          check("edge_toggle", port_owner_t, pack_toggle());
        end
        sw.press(p, 4, 1);
        sw.press(p, 4, 12);
        own[p] = (own[p] + 1) % 3;
        own_t[p] = 1 - own_t[p];
        check("edge_relock", port_owner, pack_own());
        check("edge_relock_t", port_owner_t, pack_toggle());
      end
    end
    do_reset(3'h6, 8'h00);
    sw.set_levels(4'hf);
    repeat (20) @(negedge clk_sys_i);
    check("reserved_owner", port_owner, 8'h00);
    check("reserved_owner_t", port_owner_t, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
